// file: dva_cfg.svh
// Constants for the DVMA arbiter and refresh block
`ifndef DVA_CFG_SVH
`define DVA_CFG_SVH
`define DVA_CLK_PERIOD_PS 4000
`define DVA_REF_PERIOD_PS 12800000
`define DVA_REF_CYCLES (`DVA_REF_PERIOD_PS / `DVA_CLK_PERIOD_PS)
`define DVA_REF_STATES 8
`define DVA_TIMEOUT_CYCLES 256
`define DVA_FC_SPECIAL 3'h7
`define DVA_FC_SYSDATA 3'h5
`define DVA_DEV_REFRESH 2'h3
`define DVA_DEV_NET 2'h2
`define DVA_DEV_VME 2'h1
`define DVA_DEV_NONE 2'h0
`define DVA_ROW_RESET 8'h00
`endif

// file: dva_pkg.sv
// Types for the DVMA arbiter and refresh block
package dva_pkg;
   typedef enum logic [5:0] {
      DVA_IDLE = 6'h01,
      DVA_REQ = 6'h02,
      DVA_OWN = 6'h04,
      DVA_AS = 6'h08,
      DVA_OFF = 6'h10,
      DVA_END = 6'h20
   } dva_state_t;

   typedef struct packed {
      logic [2:0] function_code;
      logic addr_strobe;
      logic upper_data_strobe;
      logic lower_data_strobe;
      logic net_rd;
      logic net_wr;
   } dva_drv_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic tap_q;
      logic pulse;
   } dva_div_t;
endpackage

// file: dva_refresh_timer.sv
// Refresh divider that raises a tick once per refresh period
`timescale 1ns/1ps
`include "dva_cfg.svh"
module dva_refresh_timer
   import dva_pkg::*;
#(
   parameter int unsigned PERIOD = `DVA_REF_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   output logic tick_o
);
   dva_div_t s_q, s_d;
   logic tap;

   always_comb begin
      s_d = s_q;
      if (s_q.cnt == 16'(PERIOD - 1)) begin
         s_d.cnt = 16'h0000;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
      tap = (s_q.cnt >= 16'(PERIOD / 2));
      s_d.tap_q = tap;
      s_d.pulse = tap & ~s_q.tap_q;  // Low-to-high tap transition
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.pulse;
endmodule // dva_refresh_timer

// file: dva_arbiter.sv
// DVMA arbiter with refresh request, bus handshake and strobe generation
`timescale 1ns/1ps
`include "dva_cfg.svh"
// Operation
// - Priority: refresh, then network, then VME
// - Per-requester flop set on edge, cleared by enable (network flop by net_req_clear_i)
// - Latched requests synchronized before arbitration
// - Request bus; enable after grant, strobe negated
// - Arbitrate during running processor cycle
// - Drive strobes and codes while owning
// - Fixed device and function codes; strobes fixed for refresh, from byte select (network) or VME inputs
// - Address strobe one clock after ownership
// - Strobe ends on return, completion or timeout
// - Refresh request every 12.8 microseconds
// - Refresh enable drives row counter, advances
// - Row counter drives address bits two-nine
// - Refresh asserts both bank selects
// - Refresh cycle lasts eight states
// - Function code 7 is special cycle
module dva_arbiter
   import dva_pkg::*;
#(
   parameter int unsigned REF_PERIOD = `DVA_REF_CYCLES,
   parameter int unsigned TIMEOUT = `DVA_TIMEOUT_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic refresh_req_i,
   input wire logic net_req_strobe_i,
   input wire logic net_req_clear_i,
   input wire logic vme_req_i,
   input wire logic net_byte_sel_i,
   input wire logic net_write_i,
   input wire logic vme_lower_strobe_i,
   input wire logic vme_upper_strobe_i,
   input wire logic cpu_bus_grant_i,
   input wire logic cpu_addr_strobe_i,
   input wire logic as_in_return_i,
   input wire logic data_ack_i,
   output logic cpu_bus_request_o,
   output logic cpu_bus_request_n_o,
   output logic refresh_grant_en_o,
   output logic net_grant_en_o,
   output logic vme_grant_en_o,
   output logic [1:0] dev_code_o,
   output logic cycle_own_o,
   output logic [2:0] function_code_o,
   output logic [2:0] function_code_oe_o,
   output logic addr_strobe_o,
   output logic addr_strobe_oe_o,
   output logic upper_data_strobe_o,
   output logic upper_data_strobe_oe_o,
   output logic lower_data_strobe_o,
   output logic lower_data_strobe_oe_o,
   output logic net_rd_o,
   output logic net_rd_oe_o,
   output logic net_wr_o,
   output logic net_wr_oe_o,
   output logic [7:0] refresh_row_addr_o,
   output logic refresh_row_addr_oe_o,
   output logic bank_sel_zero_o,
   output logic bank_sel_one_o,
   output logic special_cycle_o,
   output logic timeout_err_o
);

   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed {
      dva_state_t st;
      logic [2:0] src_q;
      logic [2:0] pend;
      logic [2:0] sync;
      logic [1:0] win;
      logic [2:0] en;
      logic br;
      logic own;
      logic as_on_delayed;
      logic state7_complete;
      logic [3:0] ref_cnt;
      logic [8:0] to_cnt;
      logic err;
      logic [7:0] row;
      dva_drv_t drv;
      logic ref_en_q;
   } dva_state_rec_t;

   dva_state_rec_t s_q, s_d;
   logic ref_tick;
   logic [2:0] src_now;
   logic as_off_term;

   // ----------------------------------------
   // Refresh divider
   // ----------------------------------------
   dva_refresh_timer #(
      .PERIOD(REF_PERIOD)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .tick_o(ref_tick)
   );

   // ----------------------------------------
   // Priority pick
   // ----------------------------------------
   function automatic logic [1:0] pick(input logic [2:0] r);
      if (r[0]) begin
         pick = `DVA_DEV_REFRESH;
      end else if (r[1]) begin
         pick = `DVA_DEV_NET;
      end else if (r[2]) begin
         pick = `DVA_DEV_VME;
      end else begin
         pick = `DVA_DEV_NONE;
      end
   endfunction

   function automatic logic [2:0] onehot(input logic [1:0] d);
      case (d)
         `DVA_DEV_REFRESH: onehot = 3'h1;
         `DVA_DEV_NET: onehot = 3'h2;
         `DVA_DEV_VME: onehot = 3'h4;
         default: onehot = 3'h0;
      endcase
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      src_now = {vme_req_i, net_req_strobe_i, refresh_req_i | ref_tick};
      s_d.src_q = src_now;
      // Set on rising edge wins over the enable clear
      s_d.pend[0] = (src_now[0] & ~s_q.src_q[0]) | (s_q.pend[0] & ~s_q.en[0]);
      s_d.pend[1] = (src_now[1] & ~s_q.src_q[1]) | (s_q.pend[1] & ~net_req_clear_i);
      s_d.pend[2] = (src_now[2] & ~s_q.src_q[2]) | (s_q.pend[2] & ~s_q.en[2]);
      s_d.sync = s_q.pend & ~s_q.en;
      s_d.state7_complete = data_ack_i & s_q.drv.addr_strobe;
      as_off_term = 1'b0;
      if (s_q.win == `DVA_DEV_REFRESH) begin
         as_off_term = as_in_return_i | (s_q.ref_cnt >= 4'(`DVA_REF_STATES - 2));
      end else begin
         as_off_term = s_q.state7_complete | s_q.err;
      end
      case (s_q.st)
         DVA_IDLE: begin
            // Runs while processor still owns the bus
            if (s_q.sync != 3'h0) begin
               s_d.win = pick(s_q.sync);
               s_d.br = 1'b1;
               s_d.st = DVA_REQ;
            end
         end
         DVA_REQ: begin
            // Processor grants and finishes its cycle
            if (cpu_bus_grant_i & ~cpu_addr_strobe_i) begin
               s_d.en = onehot(s_q.win);
               s_d.own = 1'b1;
               s_d.ref_cnt = 4'h0;
               s_d.to_cnt = 9'h000;
               s_d.st = DVA_OWN;
            end
         end
         DVA_OWN: begin
            s_d.as_on_delayed = 1'b1;
            s_d.br = 1'b0;
            s_d.ref_cnt = s_q.ref_cnt + 4'h1;
            s_d.st = DVA_AS;
         end
         DVA_AS: begin
            s_d.ref_cnt = s_q.ref_cnt + 4'h1;
            s_d.to_cnt = s_q.to_cnt + 9'h001;
            if (s_q.to_cnt == 9'(TIMEOUT - 1)) begin
               s_d.err = 1'b1;
            end
            if (as_off_term) begin
               s_d.as_on_delayed = 1'b0;
               s_d.st = DVA_OFF;
            end
         end
         DVA_OFF: begin
            s_d.ref_cnt = s_q.ref_cnt + 4'h1;
            s_d.en = 3'h0;
            s_d.st = DVA_END;
         end
         DVA_END: begin
            s_d.own = 1'b0;
            s_d.err = 1'b0;
            s_d.win = `DVA_DEV_NONE;
            s_d.st = DVA_IDLE;
         end
         default: begin
            s_d.st = DVA_IDLE;
         end
      endcase
      s_d.drv = '0;
      if (s_d.own) begin
         case (s_d.win)
            `DVA_DEV_REFRESH: begin
               s_d.drv.function_code = `DVA_FC_SPECIAL;
            end
            `DVA_DEV_NET: begin
               s_d.drv.function_code = `DVA_FC_SYSDATA;
               s_d.drv.lower_data_strobe = 1'b1;
               s_d.drv.upper_data_strobe = ~net_byte_sel_i;
               s_d.drv.net_rd = s_d.as_on_delayed & ~net_write_i;
               s_d.drv.net_wr = s_d.as_on_delayed & net_write_i;
            end
            default: begin
               s_d.drv.function_code = `DVA_FC_SYSDATA;
               s_d.drv.lower_data_strobe = vme_lower_strobe_i;
               s_d.drv.upper_data_strobe = vme_upper_strobe_i;
            end
         endcase
         s_d.drv.addr_strobe = s_d.as_on_delayed;
      end
      s_d.ref_en_q = s_d.en[0];
      if (s_q.ref_en_q & ~s_d.ref_en_q) begin
         s_d.row = s_q.row + 8'h01;  // Trailing edge advances row
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.st <= DVA_IDLE;
         s_q.win <= `DVA_DEV_NONE;
         s_q.row <= `DVA_ROW_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs, all from flops
   // ----------------------------------------
   logic refr;
   assign refr = s_q.en[0];
   assign cpu_bus_request_o = s_q.br;
   assign cpu_bus_request_n_o = ~s_q.br;
   assign refresh_grant_en_o = s_q.en[0];
   assign net_grant_en_o = s_q.en[1];
   assign vme_grant_en_o = s_q.en[2];
   assign dev_code_o = s_q.own ? s_q.win : `DVA_DEV_NONE;
   assign cycle_own_o = s_q.own;
   assign function_code_o = s_q.drv.function_code;
   assign function_code_oe_o = {3{s_q.own}};
   assign addr_strobe_o = s_q.drv.addr_strobe;
   assign addr_strobe_oe_o = s_q.own;
   assign upper_data_strobe_o = s_q.drv.upper_data_strobe;
   assign upper_data_strobe_oe_o = s_q.own;
   assign lower_data_strobe_o = s_q.drv.lower_data_strobe;
   assign lower_data_strobe_oe_o = s_q.own;
   assign net_rd_o = s_q.drv.net_rd;
   assign net_rd_oe_o = s_q.own;
   assign net_wr_o = s_q.drv.net_wr;
   assign net_wr_oe_o = s_q.own;
   assign refresh_row_addr_o = s_q.row;
   assign refresh_row_addr_oe_o = refr;
   assign bank_sel_zero_o = refr;
   assign bank_sel_one_o = refr;
   assign special_cycle_o = s_q.own & (s_q.drv.function_code == `DVA_FC_SPECIAL);
   assign timeout_err_o = s_q.err;
endmodule // dva_arbiter

// file: dva_arbiter_monitor.sv
// Checker for the DVMA arbiter ports
`timescale 1ns/1ps
module dva_arbiter_monitor (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic cpu_bus_grant_i,
   input wire logic cpu_addr_strobe_i,
   input wire logic as_in_return_i,
   input wire logic net_byte_sel_i,
   input wire logic vme_lower_strobe_i,
   input wire logic vme_upper_strobe_i,
   input wire logic cpu_bus_request_o,
   input wire logic refresh_grant_en_o,
   input wire logic net_grant_en_o,
   input wire logic vme_grant_en_o,
   input wire logic [1:0] dev_code_o,
   input wire logic cycle_own_o,
   input wire logic [2:0] function_code_o,
   input wire logic [2:0] function_code_oe_o,
   input wire logic addr_strobe_o,
   input wire logic addr_strobe_oe_o,
   input wire logic upper_data_strobe_o,
   input wire logic lower_data_strobe_o,
   input wire logic [7:0] refresh_row_addr_o,
   input wire logic refresh_row_addr_oe_o,
   input wire logic bank_sel_zero_o,
   input wire logic bank_sel_one_o,
   input wire logic special_cycle_o
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] row_q;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) row_q <= 8'h00;
      else if (refresh_grant_en_o) row_q <= refresh_row_addr_o;
   end
   sequence s_own_up; $rose(cycle_own_o); endsequence
   sequence s_ref_as; $rose(addr_strobe_o) && refresh_grant_en_o; endsequence
   a_own_after_grant: assert property (s_own_up |-> $past(cpu_bus_request_o) &&
      $past(cpu_bus_grant_i) && !$past(cpu_addr_strobe_i)) else $error("early ownership");
   a_as_one_later: assert property (s_own_up |-> !addr_strobe_o ##1 addr_strobe_o)
      else $error("strobe not one clock late");
   a_oe_follow_own: assert property ((addr_strobe_oe_o == cycle_own_o) &&
      (function_code_oe_o == {3{cycle_own_o}})) else $error("drivers not tied to ownership");
   a_refresh_codes: assert property (refresh_grant_en_o && cycle_own_o |-> dev_code_o == 2'h3
      && function_code_o == 3'h7 && !upper_data_strobe_o && !lower_data_strobe_o)
      else $error("refresh codes wrong");
   a_net_codes: assert property (net_grant_en_o && cycle_own_o |-> dev_code_o == 2'h2 &&
      function_code_o == 3'h5 && lower_data_strobe_o && upper_data_strobe_o == !net_byte_sel_i)
      else $error("network codes wrong");
   a_vme_codes: assert property (vme_grant_en_o && cycle_own_o |-> dev_code_o == 2'h1 &&
      function_code_o == 3'h5 && upper_data_strobe_o == vme_upper_strobe_i &&
      lower_data_strobe_o == vme_lower_strobe_i) else $error("external codes wrong");
   a_one_enable: assert property ($onehot0({refresh_grant_en_o, net_grant_en_o, vme_grant_en_o}))
      else $error("several enables");
   a_bank_row_on: assert property (refresh_grant_en_o |-> bank_sel_zero_o && bank_sel_one_o
      && refresh_row_addr_oe_o) else $error("refresh selects missing");
   a_row_step: assert property ($fell(refresh_grant_en_o) |-> ##[1:2]
      refresh_row_addr_o == row_q + 8'h01) else $error("row did not advance");
   a_refresh_short: assert property (s_ref_as |-> ##[1:8] !addr_strobe_o)
      else $error("refresh too long");
   a_return_ends: assert property (addr_strobe_o && as_in_return_i && refresh_grant_en_o
      |-> ##[1:2] !addr_strobe_o) else $error("strobe not ended");
   a_special_fc: assert property (special_cycle_o == (cycle_own_o && function_code_o == 3'h7))
      else $error("special flag wrong");
endmodule // dva_arbiter_monitor

bind dva_arbiter dva_arbiter_monitor u_mon (.*);

// file: dva_cpu_model.sv
// Processor bus model that grants the bus and answers strobes
`timescale 1ns/1ps
module dva_cpu_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic cpu_bus_request_o,
   input wire logic addr_strobe_o,
   input wire logic addr_strobe_oe_o,
   input wire logic slow_i,
   input wire logic mute_i,
   output logic cpu_bus_grant_i,
   output logic cpu_addr_strobe_i,
   output logic data_ack_i,
   output logic as_in_return_i
);
   logic [2:0] ph_q;
   logic [3:0] wt_q;
   logic [3:0] ak_q;
   logic [3:0] dl;
   assign dl = slow_i ? 4'h5 : 4'h1;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ph_q <= 3'h0;
         wt_q <= 4'h0;
         ak_q <= 4'h0;
         cpu_bus_grant_i <= 1'b0;
         cpu_addr_strobe_i <= 1'b0;
         data_ack_i <= 1'b0;
         as_in_return_i <= 1'b0;
      end else begin
         ph_q <= ph_q + 3'h1;
         wt_q <= cpu_bus_request_o ? wt_q + 4'h1 : 4'h0;
         ak_q <= addr_strobe_o ? ak_q + {3'h0, ak_q != 4'hf} : 4'h0;
         // Own cycle runs to phase 7, none starts while granted
         if (cpu_addr_strobe_i) cpu_addr_strobe_i <= ph_q != 3'h7;
         else cpu_addr_strobe_i <= !cpu_bus_grant_i && ph_q == 3'h0;
         cpu_bus_grant_i <= (cpu_bus_request_o && wt_q >= dl) ||
            (cpu_bus_grant_i && (cpu_bus_request_o || addr_strobe_oe_o));
         data_ack_i <= addr_strobe_o && !mute_i && ak_q >= dl;
         as_in_return_i <= addr_strobe_o && !mute_i && ak_q >= dl;
      end
   end
endmodule // dva_cpu_model

// file: dva_arbiter_tb.sv
// Testbench for the DVMA arbiter
`timescale 1ns/1ps
module dva_arbiter_tb;
   import dva_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic refresh_req_i = 1'b0, net_req_strobe_i = 1'b0, net_req_clear_i = 1'b0, vme_req_i = 1'b0;
   logic net_byte_sel_i = 1'b0, net_write_i = 1'b0, vme_lower_strobe_i = 1'b0;
   logic vme_upper_strobe_i = 1'b0, slow_i = 1'b0, mute_i = 1'b0, own_q = 1'b0, to_q = 1'b0;
   logic cpu_bus_grant_i, cpu_addr_strobe_i, as_in_return_i, data_ack_i, cycle_own_o;
   logic cpu_bus_request_o, cpu_bus_request_n_o, refresh_grant_en_o, net_grant_en_o;
   logic vme_grant_en_o, addr_strobe_o, addr_strobe_oe_o, upper_data_strobe_o;
   logic upper_data_strobe_oe_o, lower_data_strobe_o, lower_data_strobe_oe_o, net_rd_o;
   logic net_rd_oe_o, net_wr_o, net_wr_oe_o, refresh_row_addr_oe_o, bank_sel_zero_o;
   logic bank_sel_one_o, special_cycle_o, timeout_err_o;
   logic [1:0] dev_code_o;
   logic [2:0] function_code_o, function_code_oe_o;
   logic [7:0] refresh_row_addr_o;
   logic [6:0] q[$];
   int n_mismatch = 0, n_checks = 0, n_own = 0, i;
   time t_last = 0, t1;

   dva_arbiter #(.REF_PERIOD(4000), .TIMEOUT(16)) DUT (.*);
   dva_cpu_model u_cpu (.*);

   always #2 core_clk_i = ~core_clk_i;

   task automatic test_done;
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(posedge core_clk_i) begin
      own_q <= cycle_own_o;
      to_q <= to_q | (timeout_err_o === 1'b1);
      net_req_clear_i <= net_grant_en_o;
      if (cycle_own_o === 1'b1 && own_q === 1'b0) begin
         n_own++;
         t_last = $time;
         chk(q.size() != 0, "unexpected cycle");
         if (q.size() != 0) chk({dev_code_o, function_code_o, upper_data_strobe_o,
            lower_data_strobe_o} === q.pop_front(), "cycle codes");
      end
   end

   task automatic wt(input int n, input int lim);
      int t;
      t = 0;
      while ((n_own < n || cycle_own_o !== 1'b0) && t < lim) begin
         @(posedge core_clk_i);
         t++;
      end
      chk(t < lim, "cycle missing");
      repeat (3) @(posedge core_clk_i);
   endtask

   task automatic post(input logic [2:0] m);
      int n;
      n = n_own + $countones(m);
      @(posedge core_clk_i);
      if (m[0]) q.push_back({2'h3, 3'h7, 2'h0});
      if (m[1]) q.push_back({2'h2, 3'h5, ~net_byte_sel_i, 1'b1});
      if (m[2]) q.push_back({2'h1, 3'h5, vme_upper_strobe_i, vme_lower_strobe_i});
      {vme_req_i, net_req_strobe_i, refresh_req_i} <= m;
      @(posedge core_clk_i);
      {vme_req_i, net_req_strobe_i, refresh_req_i} <= 3'h0;
      wt(n, 400);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h4daff165));
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk_i);
         {net_byte_sel_i, net_write_i, vme_lower_strobe_i, vme_upper_strobe_i} <= 4'($urandom);
         slow_i <= i[0];
         post(i < 6 ? 3'(1 << (i % 3)) : 3'($urandom_range(7, 1)));
      end
      chk(!to_q, "timeout without cause");
      mute_i <= 1'b1;
      post(3'h5);
      chk(to_q, "timeout missing");
      mute_i <= 1'b0;
      q.push_back({2'h3, 3'h7, 2'h0});
      wt(n_own + 1, 4400);
      t1 = t_last;
      q.push_back({2'h3, 3'h7, 2'h0});
      wt(n_own + 1, 4400);
      chk((t_last - t1) / 4 >= 3990 && (t_last - t1) / 4 <= 4010, "refresh period");
      test_done();
   end

   initial begin
      #80000;
      n_mismatch++;
      test_done();
   end
endmodule // dva_arbiter_tb
